// *** pkg/ssa_pkg.sv ***
`default_nettype none
package ssa_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam logic [2:0] ADDR_DATA_LINE = 3'h0;
   localparam logic [2:0] ADDR_CLOCK_LINE = 3'h1;
   localparam logic [2:0] ADDR_CONTROL = 3'h2;
   localparam logic [2:0] ADDR_FALL_COND = 3'h3;
   localparam logic [2:0] ADDR_RISE_COND = 3'h4;
   localparam logic [2:0] ADDR_SAMPLED = 3'h5;
   localparam logic [2:0] ADDR_EDGE_FLAG = 3'h6;
   localparam int CTRL_BLOCK_EN = 0;
   localparam int CTRL_STRETCH_EN = 1;
   localparam int CTRL_COND_STRETCH_EN = 2;
   localparam int CTRL_STRETCH_ACTIVE = 3;
   localparam logic DRIVE_RESET = 1'h1;
   localparam logic FLAG_RESET = 1'h0;
   localparam logic [7:0] READ_ZERO = 8'h00;
endpackage
`default_nettype wire

// *** hw/ssa_sync.sv ***
`default_nettype none
// Two-stage synchroniser with edge strobes from the second and third stage
module ssa_sync (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic asyncIn,
   input wire logic resetValue,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   // Meta stage is read by the second stage only
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta_reg <= ssa_pkg::DRIVE_RESET;
         sync_reg <= ssa_pkg::DRIVE_RESET;
         prev_reg <= ssa_pkg::DRIVE_RESET;
      end else begin
         meta_reg <= asyncIn;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end
   assign level = sync_reg;
   assign rise = sync_reg & ~prev_reg;
   assign fall = ~sync_reg & prev_reg;
   logic unusedResetValue;
   assign unusedResetValue = resetValue;
endmodule // ssa_sync
`default_nettype wire

// *** hw/ssa_regread.sv ***
`default_nettype none
// Read-data multiplexer; unused upper bits read as zero
module ssa_regread (
   input wire logic [2:0] addr,
   input wire logic dataPin,
   input wire logic clockPin,
   input wire logic [3:0] ctrlBits,
   input wire logic fallFlag,
   input wire logic riseFlag,
   input wire logic sampled,
   input wire logic edgeFlag,
   output logic [7:0] rdValue
);
   always_comb begin
      rdValue = ssa_pkg::READ_ZERO;
      unique case (addr)
         ssa_pkg::ADDR_DATA_LINE: rdValue[0] = dataPin;
         ssa_pkg::ADDR_CLOCK_LINE: rdValue[0] = clockPin;
         ssa_pkg::ADDR_CONTROL: rdValue[3:0] = ctrlBits;
         ssa_pkg::ADDR_FALL_COND: rdValue[0] = fallFlag;
         ssa_pkg::ADDR_RISE_COND: rdValue[0] = riseFlag;
         ssa_pkg::ADDR_SAMPLED: rdValue[0] = sampled;
         ssa_pkg::ADDR_EDGE_FLAG: rdValue[0] = edgeFlag;
         default: rdValue = ssa_pkg::READ_ZERO;
      endcase
   end
endmodule // ssa_regread
`default_nettype wire

// *** hw/ssa_sync_serial_assist.sv ***
`default_nettype none
module ssa_sync_serial_assist (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [2:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [7:0] rdData,
   input wire logic portBClockIn,
   input wire logic portBDataIn,
   input wire logic portBClockOut,
   input wire logic portBDataOut,
   input wire logic portBClockOe_n,
   input wire logic portBDataOe_n,
   output logic pb4Out,
   output logic pb4Oe_n,
   output logic pb5Out,
   output logic pb5Oe_n,
   output logic fallCondIrq,
   output logic riseCondIrq
);
   logic dataLineDrive_reg;
   logic clockLineDrive_reg;
   logic blockEn_reg;
   logic stretchEn_reg;
   logic condStretchEn_reg;
   logic stretchActive_reg;
   logic fallCondDetected_reg;
   logic riseCondDetected_reg;
   logic sampledData_reg;
   logic newSampleFlag_reg;
   logic [7:0] rdData_next;
   logic clockLevel;
   logic clockRise;
   logic clockFall;
   logic dataLevel;
   logic dataRise;
   logic dataFall;
   logic fallCond;
   logic riseCond;
   logic stretchSet;
   logic writeSampled;

   ssa_sync clockSync (
      .ref_clk(ref_clk),
      .reset(reset),
      .asyncIn(portBClockIn),
      .resetValue(ssa_pkg::DRIVE_RESET),
      .level(clockLevel),
      .rise(clockRise),
      .fall(clockFall)
   );

   ssa_sync dataSync (
      .ref_clk(ref_clk),
      .reset(reset),
      .asyncIn(portBDataIn),
      .resetValue(ssa_pkg::DRIVE_RESET),
      .level(dataLevel),
      .rise(dataRise),
      .fall(dataFall)
   );

   assign fallCond = blockEn_reg & dataFall & clockLevel;
   assign riseCond = blockEn_reg & dataRise & clockLevel;
   // Conditional stretch uses flag set before this edge
   assign stretchSet = blockEn_reg & clockFall &
      (stretchEn_reg | (condStretchEn_reg & fallCondDetected_reg));
   assign writeSampled = wrStb & (addr == ssa_pkg::ADDR_SAMPLED);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dataLineDrive_reg <= ssa_pkg::DRIVE_RESET;
      end else if (wrStb && addr == ssa_pkg::ADDR_DATA_LINE) begin
         dataLineDrive_reg <= wrData[0];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         clockLineDrive_reg <= ssa_pkg::DRIVE_RESET;
      end else if (wrStb && addr == ssa_pkg::ADDR_CLOCK_LINE) begin
         clockLineDrive_reg <= wrData[0];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         blockEn_reg <= ssa_pkg::FLAG_RESET;
         stretchEn_reg <= ssa_pkg::FLAG_RESET;
         condStretchEn_reg <= ssa_pkg::FLAG_RESET;
      end else if (wrStb && addr == ssa_pkg::ADDR_CONTROL) begin
         blockEn_reg <= wrData[ssa_pkg::CTRL_BLOCK_EN];
         stretchEn_reg <= wrData[ssa_pkg::CTRL_STRETCH_EN];
         condStretchEn_reg <= wrData[ssa_pkg::CTRL_COND_STRETCH_EN];
      end
   end
   // Release on sampled write; new stretch wins over release
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         stretchActive_reg <= ssa_pkg::FLAG_RESET;
      end else if (stretchSet) begin
         stretchActive_reg <= 1'h1;
      end else if (writeSampled || !blockEn_reg) begin
         stretchActive_reg <= 1'h0;
      end
   end

   // Fall flag; a detection beats a clearing write
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fallCondDetected_reg <= ssa_pkg::FLAG_RESET;
      end else if (fallCond) begin
         fallCondDetected_reg <= 1'h1;
      end else if (wrStb && addr == ssa_pkg::ADDR_FALL_COND) begin
         fallCondDetected_reg <= 1'h0;
      end
   end

   // Rise flag; a detection beats a clearing write
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         riseCondDetected_reg <= ssa_pkg::FLAG_RESET;
      end else if (riseCond) begin
         riseCondDetected_reg <= 1'h1;
      end else if (wrStb && addr == ssa_pkg::ADDR_RISE_COND) begin
         riseCondDetected_reg <= 1'h0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         fallCondIrq <= ssa_pkg::FLAG_RESET;
         riseCondIrq <= ssa_pkg::FLAG_RESET;
      end else begin
         fallCondIrq <= fallCond;
         riseCondIrq <= riseCond;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sampledData_reg <= ssa_pkg::FLAG_RESET;
      end else if (blockEn_reg && clockRise) begin
         sampledData_reg <= dataLevel;
      end
   end

   // New-sample flag; a fresh edge beats the clearing read
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         newSampleFlag_reg <= ssa_pkg::FLAG_RESET;
      end else if (blockEn_reg && clockRise) begin
         newSampleFlag_reg <= 1'h1;
      end else if (rdStb && addr == ssa_pkg::ADDR_SAMPLED) begin
         newSampleFlag_reg <= 1'h0;
      end
   end

   // Open drain while block enabled: enable only when pulling low; else port B outputs pass through
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pb4Out <= ssa_pkg::FLAG_RESET;
         pb4Oe_n <= ssa_pkg::DRIVE_RESET;
         pb5Out <= ssa_pkg::FLAG_RESET;
         pb5Oe_n <= ssa_pkg::DRIVE_RESET;
      end else if (blockEn_reg) begin
         pb4Out <= 1'h0;
         pb4Oe_n <= ~(~clockLineDrive_reg | stretchActive_reg | stretchSet);
         pb5Out <= 1'h0;
         pb5Oe_n <= dataLineDrive_reg;
      end else begin
         pb4Out <= portBClockOut;
         pb4Oe_n <= portBClockOe_n;
         pb5Out <= portBDataOut;
         pb5Oe_n <= portBDataOe_n;
      end
   end

   ssa_regread readMux (
      .addr(addr),
      .dataPin(dataLevel),
      .clockPin(clockLevel),
      .ctrlBits({stretchActive_reg, condStretchEn_reg, stretchEn_reg,
         blockEn_reg}),
      .fallFlag(fallCondDetected_reg),
      .riseFlag(riseCondDetected_reg),
      .sampled(sampledData_reg),
      .edgeFlag(newSampleFlag_reg),
      .rdValue(rdData_next)
   );

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdData <= ssa_pkg::READ_ZERO;
      end else if (rdStb) begin
         rdData <= rdData_next;
      end else begin
         rdData <= ssa_pkg::READ_ZERO;
      end
   end
endmodule // ssa_sync_serial_assist
`default_nettype wire

// *** dv/ssa_chk.sv ***
`default_nettype none
module ssa_chk (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic rdStb,
   input wire logic [7:0] rdData,
   input wire logic portBClockIn,
   input wire logic portBDataIn,
   input wire logic fallCondIrq,
   input wire logic riseCondIrq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_RD_IDLE: assert property (
      !$past(rdStb) |-> rdData == 8'h00) else $error("idle read data");
   AST_RD_UPPER: assert property (
      $past(rdStb) |-> rdData[7:4] == 4'h0) else $error("upper bits set");
   AST_FALL_ONE: assert property (
      fallCondIrq |=> !fallCondIrq) else $error("fall irq too long");
   AST_RISE_ONE: assert property (
      riseCondIrq |=> !riseCondIrq) else $error("rise irq too long");
   AST_IRQ_EXCL: assert property (
      !(fallCondIrq && riseCondIrq)) else $error("both irqs at once");
   AST_FALL_CAUSE: assert property (
      fallCondIrq |-> !$past(portBDataIn, 3) && $past(portBDataIn, 4) &&
      $past(portBClockIn, 3))
      else $error("fall irq without cause");
   AST_RISE_CAUSE: assert property (
      riseCondIrq |-> $past(portBDataIn, 3) && !$past(portBDataIn, 4) &&
      $past(portBClockIn, 3))
      else $error("rise irq without cause");
   AST_RST_QUIET: assert property (
      $fell(reset) |-> !fallCondIrq && !riseCondIrq && rdData == 8'h00)
      else $error("busy after reset");
endmodule // ssa_chk
bind ssa_sync_serial_assist ssa_chk chk (.ref_clk, .reset, .rdStb,
   .rdData, .portBClockIn, .portBDataIn, .fallCondIrq, .riseCondIrq);
`default_nettype wire

// *** dv/ssa_peer.sv ***
`default_nettype none
module ssa_peer (
   input wire logic dutClkLow,
   input wire logic dutDataLow,
   output logic clockWire,
   output logic dataWire
);
   timeunit 1ns;
   timeprecision 1ns;
   logic clkRel = 1'b1;
   logic dataRel = 1'b1;
   // Pull-ups: a released line floats high
   assign clockWire = clkRel & ~dutClkLow;
   assign dataWire = dataRel & ~dutDataLow;
   // One 160 ns period; the clock stands high between frames
   // Starts off the sampling edge so no flop races the pin change
   task automatic clk_pulse();
      #5;
      clkRel = 1'b0;
      #80;
      clkRel = 1'b1;
      #75;
   endtask
endmodule // ssa_peer
`default_nettype wire

// *** dv/sync_serial_bit_assist_tb.sv ***
`default_nettype none
module sync_serial_bit_assist_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wrData = 8'h00;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic [7:0] rdData;
   logic pb4Out, pb4Oe_n, pb5Out, pb5Oe_n, fallIrq, riseIrq;
   logic clockWire, dataWire;
   int errorCnt = 0, nCompared = 0, cycles = 0, fallCnt = 0, riseCnt = 0;
   ssa_sync_serial_assist dut (.ref_clk(ref_clk), .reset(reset),
      .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
      .rdData(rdData), .portBClockIn(clockWire), .portBDataIn(dataWire),
      .portBClockOut(1'b1), .portBDataOut(1'b1), .portBClockOe_n(1'b0),
      .portBDataOe_n(1'b0), .pb4Out(pb4Out), .pb4Oe_n(pb4Oe_n),
      .pb5Out(pb5Out), .pb5Oe_n(pb5Oe_n), .fallCondIrq(fallIrq),
      .riseCondIrq(riseIrq));
   ssa_peer peer (.dutClkLow(!pb4Oe_n && !pb4Out),
      .dutDataLow(!pb5Oe_n && !pb5Out), .clockWire(clockWire),
      .dataWire(dataWire));
   initial forever #10 ref_clk = ~ref_clk;
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge ref_clk);
      rdStb <= 1'b0;
      #1;
      check($sformatf("reg %0d", a), rdData, exp);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge ref_clk);
      wrStb <= 1'b0;
   endtask
   // Covers the three-cycle synchroniser path with margin
   task automatic settle();
      repeat (6) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      fallCnt += int'(fallIrq === 1'b1);
      riseCnt += int'(riseIrq === 1'b1);
      if (cycles == 20000) begin
         errorCnt++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 8; i++) rd(3'(i), (i < 2) ? 8'h01 : 8'h00);
      wr(ssa_pkg::ADDR_CONTROL, 8'hF1);
      settle();
      rd(ssa_pkg::ADDR_CONTROL, 8'h01);
      check("pb4Oe_n", 8'(pb4Oe_n), 8'h01);
      check("pb4Out", 8'(pb4Out), 8'h00);
      wr(ssa_pkg::ADDR_DATA_LINE, 8'h00);
      settle();
      rd(ssa_pkg::ADDR_DATA_LINE, 8'h00);
      check("pb5Oe_n", 8'(pb5Oe_n), 8'h00);
      rd(ssa_pkg::ADDR_FALL_COND, 8'h01);
      check("fall irqs", 8'(fallCnt), 8'h01);
      wr(ssa_pkg::ADDR_FALL_COND, 8'h00);
      rd(ssa_pkg::ADDR_FALL_COND, 8'h00);
      wr(ssa_pkg::ADDR_DATA_LINE, 8'h01);
      settle();
      rd(ssa_pkg::ADDR_RISE_COND, 8'h01);
      check("rise irqs", 8'(riseCnt), 8'h01);
      wr(ssa_pkg::ADDR_RISE_COND, 8'hFF);
      rd(ssa_pkg::ADDR_RISE_COND, 8'h00);
      peer.dataRel = 1'b0;
      settle();
      rd(ssa_pkg::ADDR_DATA_LINE, 8'h00);
      peer.dataRel = 1'b1;
      settle();
      wr(ssa_pkg::ADDR_FALL_COND, 8'h00);
      peer.clk_pulse();
      settle();
      rd(ssa_pkg::ADDR_EDGE_FLAG, 8'h01);
      rd(ssa_pkg::ADDR_SAMPLED, 8'h01);
      rd(ssa_pkg::ADDR_EDGE_FLAG, 8'h00);
      wr(ssa_pkg::ADDR_CONTROL, 8'h03);
      peer.clk_pulse();
      settle();
      rd(ssa_pkg::ADDR_CONTROL, 8'h0B);
      rd(ssa_pkg::ADDR_CLOCK_LINE, 8'h00);
      wr(ssa_pkg::ADDR_SAMPLED, 8'h00);
      settle();
      rd(ssa_pkg::ADDR_CONTROL, 8'h03);
      rd(ssa_pkg::ADDR_CLOCK_LINE, 8'h01);
      wr(ssa_pkg::ADDR_CONTROL, 8'h05);
      peer.clk_pulse();
      settle();
      rd(ssa_pkg::ADDR_CONTROL, 8'h05);
      peer.dataRel = 1'b0;
      settle();
      peer.clk_pulse();
      settle();
      rd(ssa_pkg::ADDR_CONTROL, 8'h0D);
      wr(ssa_pkg::ADDR_SAMPLED, 8'h00);
      settle();
      rd(ssa_pkg::ADDR_SAMPLED, 8'h00);
      wr(ssa_pkg::ADDR_RISE_COND, 8'h00);
      rd(ssa_pkg::ADDR_RISE_COND, 8'h00);
      peer.dataRel = 1'b1;
      settle();
      rd(ssa_pkg::ADDR_RISE_COND, 8'h01);
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      rd(ssa_pkg::ADDR_RISE_COND, 8'h00);
      rd(ssa_pkg::ADDR_FALL_COND, 8'h00);
      rd(ssa_pkg::ADDR_CONTROL, 8'h00);
      wr(ssa_pkg::ADDR_CONTROL, 8'h00);
      settle();
      check("pb4Oe_n off", 8'(pb4Oe_n), 8'h00);
      check("pb5Out off", 8'(pb5Out), 8'h01);
      give_verdict();
   end
endmodule // sync_serial_bit_assist_tb
`default_nettype wire
